// [alc_ctrl.sv]
/*
  Level control registers and gain stepping engine.
  Assumes a register port from a serial slave and a level comparator input.
*/
`timescale 1ns/1ps
module alc_ctrl #(
  parameter int ATTACK_BASE = alc_pkg::ATTACK_BASE_CYC,
  parameter int RELEASE_BASE = alc_pkg::RELEASE_BASE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_over_threshold,
  output logic [5:0] o_gain,
  output logic [1:0] o_comp_mode,
  output logic o_fixed_power,
  output logic [3:0] o_threshold_level_code,
  output logic [6:0] o_threshold_pct
);
  // ***********************************************
  // Registers
  // ***********************************************
  logic [7:0] timing_reg, timing_next;
  logic [7:0] mode_reg, mode_next;
  logic [5:0] right_gain_code_reg, right_gain_code_next;
  logic [5:0] gain_reg, gain_next;
  logic en_d_reg, en_d_next;
  logic level_control_enable;
  logic atk_tick, rel_tick;

  assign level_control_enable = mode_reg[alc_pkg::ENABLE_BIT];

  // Clamp a gain code to the 24 dB ceiling.
  function automatic logic [5:0] clamp_gain(input logic [5:0] g);
    clamp_gain = (g > alc_pkg::GAIN_MAX) ? alc_pkg::GAIN_MAX : g;
  endfunction

  // Register writes and gain stepping.
  always_comb begin
    timing_next = timing_reg;
    mode_next = mode_reg;
    right_gain_code_next = right_gain_code_reg;
    gain_next = gain_reg;
    en_d_next = level_control_enable;
    if (i_wr) begin
      if (i_addr == alc_pkg::ADDR_TIMING) begin
        timing_next = i_wdata & alc_pkg::TIMING_MASK;
      end
      if (i_addr == alc_pkg::ADDR_MODE) begin
        mode_next = i_wdata;
      end
      if (i_addr == alc_pkg::ADDR_GAIN && !level_control_enable) begin
        right_gain_code_next = i_wdata[5:0];
      end
    end
    if (!level_control_enable) begin
      gain_next = clamp_gain(right_gain_code_reg);
    end else if (!en_d_reg) begin
      gain_next = clamp_gain(right_gain_code_reg);
    end else if (i_over_threshold && atk_tick && gain_reg != 6'h00) begin
      gain_next = gain_reg - 6'h01;
    end else if (!i_over_threshold && rel_tick && gain_reg < clamp_gain(right_gain_code_reg)) begin
      gain_next = gain_reg + 6'h01;
    end
  end

  // State registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      timing_reg <= alc_pkg::TIMING_RESET;
      mode_reg <= alc_pkg::MODE_RESET;
      right_gain_code_reg <= alc_pkg::GAIN_RESET;
      gain_reg <= alc_pkg::GAIN_RESET;
      en_d_reg <= 1'b0;
    end else if (i_ce) begin
      timing_reg <= timing_next;
      mode_reg <= mode_next;
      right_gain_code_reg <= right_gain_code_next;
      gain_reg <= gain_next;
      en_d_reg <= en_d_next;
    end
  end

  // ***********************************************
  // Step timers
  // ***********************************************
  // attack interval
  alc_step_timer #(.BASE_CYC(ATTACK_BASE)) u_atk (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_run(level_control_enable & i_over_threshold),
    .i_code(timing_reg[alc_pkg::ATK_LSB +: 3]),
    .o_tick(atk_tick)
  );

  alc_step_timer #(.BASE_CYC(RELEASE_BASE)) u_rel (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_run(level_control_enable & ~i_over_threshold),
    .i_code(timing_reg[alc_pkg::REL_LSB +: 3]),
    .o_tick(rel_tick)
  );

  // Read mux and field outputs.
  always_comb begin
    case (i_addr)
      alc_pkg::ADDR_GAIN: o_rdata = {2'h0, right_gain_code_reg};
      alc_pkg::ADDR_TIMING: o_rdata = timing_reg;
      alc_pkg::ADDR_MODE: o_rdata = mode_reg;
      default: o_rdata = 8'h00;
    endcase
  end

  assign o_comp_mode = mode_reg[alc_pkg::COMP_LSB +: 2];
  assign o_fixed_power = mode_reg[alc_pkg::VFIX_BIT];
  assign o_threshold_level_code = mode_reg[3:0];
  assign o_gain = gain_reg;

  always_comb begin
    case (mode_reg[3:0])
      4'hf: o_threshold_pct = 7'd96;
      4'he: o_threshold_pct = 7'd93;
      4'hd: o_threshold_pct = 7'd90;
      4'hc: o_threshold_pct = 7'd88;
      4'hb: o_threshold_pct = 7'd85;
      default: o_threshold_pct = 7'd0;
    endcase
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  // Locked gain code.
  gain_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && level_control_enable) |=> $stable(right_gain_code_reg))
    else $error("Gain changed while locked.");
  gain_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == alc_pkg::ADDR_GAIN && !level_control_enable) |=>
    right_gain_code_reg == $past(i_wdata[5:0])) else $error("Gain write lost.");
  gain_cap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    gain_reg <= alc_pkg::GAIN_MAX) else $error("Gain above ceiling.");
  follow_code_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && !level_control_enable) |=> gain_reg == clamp_gain($past(right_gain_code_reg)))
    else $error("Gain does not follow code.");
  top_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    timing_reg[7:6] == 2'h0) else $error("Timing top bits set.");
  timing_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == alc_pkg::ADDR_TIMING) |=>
    timing_reg == ($past(i_wdata) & alc_pkg::TIMING_MASK))
    else $error("Timing write lost.");
  mode_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && i_wr && i_addr == alc_pkg::ADDR_MODE) |=> mode_reg == $past(i_wdata))
    else $error("Mode write lost.");
  load_gain_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && level_control_enable && !en_d_reg) |=>
    gain_reg == clamp_gain($past(right_gain_code_reg))) else $error("Start gain not loaded.");
  attack_dn_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && en_d_reg && level_control_enable && i_over_threshold && atk_tick
     && gain_reg != 6'h00) |=> gain_reg == $past(gain_reg) - 6'h01)
    else $error("Attack step missed.");
  release_up_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && en_d_reg && level_control_enable && !i_over_threshold && rel_tick
     && gain_reg < clamp_gain(right_gain_code_reg)) |=> gain_reg == $past(gain_reg) + 6'h01)
    else $error("Release step missed.");
  no_rise_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && en_d_reg && level_control_enable && i_over_threshold) |=>
    gain_reg <= $past(gain_reg)) else $error("Gain rose over threshold.");
  gain_floor_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_ce && en_d_reg && level_control_enable && i_over_threshold && gain_reg == 6'h00)
    |=> gain_reg == 6'h00) else $error("Gain wrapped below floor.");
  rise_cap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (en_d_reg && level_control_enable) |-> gain_reg <= clamp_gain(right_gain_code_reg))
    else $error("Gain above programmed code.");
  freeze_gain_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_ce |=> $stable(gain_reg) && $stable(mode_reg))
    else $error("State moved while frozen.");
  comp_map_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_comp_mode == mode_reg[alc_pkg::COMP_LSB +: 2]) else $error("Curve select wrong.");
  pct_map_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (mode_reg[3:0] == 4'hb) |-> o_threshold_pct == 7'd85) else $error("Percent map wrong.");

  // ***********************************************
  // Cover points
  // ***********************************************
  attack_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) atk_tick);
  release_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) rel_tick);
  enable_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    level_control_enable && !en_d_reg);
  lockout_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && i_wr && i_addr == alc_pkg::ADDR_GAIN && level_control_enable);
  floor_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    level_control_enable && gain_reg == 6'h00);
endmodule

// [alc_pkg.sv]
/*
  Constants for the automatic level control configuration block.
  Assumes a 50 MHz system clock and an 8-bit register port with address.
*/
// Operation
// - Release field sets per-step gain rise wait.
// - Attack field sets per-step gain cut wait.
// - Enable bit loads programmed gain as start.
// - Compressor field selects one of four curves.
// - Threshold mode: supply tracking or fixed power.
// - Four-bit threshold code, reset value eleven.
// - Supply tracking codes map to supply percentage.
// - Gain writes ignored while level control enabled.
// - Gain codes saturate at 24 dB code.
package alc_pkg;
  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [7:0] ADDR_GAIN = 8'h01;
  localparam logic [7:0] ADDR_TIMING = 8'h03;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] TIMING_RESET = 8'h2b;
  localparam logic [7:0] MODE_RESET = 8'h4b;
  localparam logic [5:0] GAIN_RESET = 6'h22;
  localparam logic [5:0] GAIN_MAX = 6'h2e;
  localparam logic [7:0] TIMING_MASK = 8'h3f;
  localparam int ENABLE_BIT = 7;
  localparam int REL_LSB = 3;
  localparam int ATK_LSB = 0;
  localparam int COMP_LSB = 5;
  localparam int VFIX_BIT = 4;
  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_MHZ = 50;
  localparam int ATTACK_BASE_US = 32;
  localparam int RELEASE_BASE_US = 4000;
  localparam int ATTACK_BASE_CYC = ATTACK_BASE_US * CLK_MHZ;
  localparam int RELEASE_BASE_CYC = RELEASE_BASE_US * CLK_MHZ;
endpackage

// [alc_step_timer.sv]
/*
  Step interval timer: pulses once per base period times two to the code.
  Assumes the code is held stable by the caller while counting.
*/
`timescale 1ns/1ps
module alc_step_timer #(
  parameter int BASE_CYC = 1600
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [2:0] i_code,
  output logic o_tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] limit;

  // Count to the base period shifted by the code; wait doubles per code.
  always_comb begin
    limit = (BASE_CYC << i_code) - 1;
    cnt_next = cnt_reg;
    o_tick = 1'b0;
    if (!i_run) begin
      cnt_next = '0;
    end else if (cnt_reg >= limit) begin
      cnt_next = '0;
      o_tick = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  // Register the count.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// [alc_tb.sv]
/*
  Self-checking bench for the level control block: registers and gain steps.
  Assumes alc_pkg and alc_ctrl are compiled first; short step bases are used.
*/
`timescale 1ns/1ps
module tb;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr = 1'b0;
  logic i_over_threshold = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [5:0] o_gain;
  logic [1:0] o_comp_mode;
  logic o_fixed_power;
  logic [3:0] o_threshold_level_code;
  logic [6:0] o_threshold_pct;
  logic [7:0] t_m = 8'h2b, m_m = 8'h4b, g_m = 8'h22;
  logic [31:0] seed = 32'h0000000c, q[$];
  int n_errors = 0, num_checks = 0, n;
  event smp;
  alc_ctrl #(.ATTACK_BASE(4), .RELEASE_BASE(8)) u_dut (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_over_threshold(i_over_threshold), .o_gain(o_gain),
    .o_comp_mode(o_comp_mode), .o_fixed_power(o_fixed_power),
    .o_threshold_level_code(o_threshold_level_code), .o_threshold_pct(o_threshold_pct));
  // Clock of 20 ns period.
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] pct(input logic [3:0] c);
    case (c)
      4'hf: return 7'h60;
      4'he: return 7'h5d;
      4'hd: return 7'h5a;
      4'hc: return 7'h58;
      4'hb: return 7'h55;
      default: return 7'h00;
    endcase
  endfunction
  function automatic logic [7:0] rd(input logic [7:0] a);
    if (a == alc_pkg::ADDR_GAIN) return {2'b00, g_m[5:0]};
    if (a == alc_pkg::ADDR_TIMING) return t_m;
    if (a == alc_pkg::ADDR_MODE) return m_m;
    return 8'h00;
  endfunction
  // Codes above the top step clamp.
  function automatic logic [5:0] clampg();
    return (g_m[5:0] > 6'h2e) ? 6'h2e : g_m[5:0];
  endfunction
  task automatic check(input logic [31:0] obs, input logic [31:0] exp);
    num_checks++;
    if (obs !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, obs, exp);
    end
  endtask
  task automatic complete_run();
    // Let the monitor take the last note before the verdict.
    @(posedge i_sys_clk);
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor takes the oldest note when a result is flagged.
  always @(smp) begin
    check({o_rdata, 2'b00, o_gain, 1'b0, o_threshold_pct, 1'b0, o_comp_mode,
      o_fixed_power, o_threshold_level_code}, q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(posedge i_sys_clk);
    #1;
    i_wr = 1'b0;
    if (i_ce && a == alc_pkg::ADDR_TIMING) t_m = d & alc_pkg::TIMING_MASK;
    if (i_ce && a == alc_pkg::ADDR_GAIN && !m_m[7]) g_m = {2'b00, d[5:0]};
    if (i_ce && a == alc_pkg::ADDR_MODE) m_m = d;
  endtask
  task automatic look(input logic [7:0] a, input logic [5:0] ge);
    @(posedge i_sys_clk);
    #1;
    i_addr = a;
    q.push_back({rd(a), 2'b00, ge, 1'b0, pct(m_m[3:0]), 1'b0, m_m[6:0]});
    @(negedge i_sys_clk);
    -> smp;
  endtask
  // Counts cycles until the gain moves; a stuck gain ends the run.
  task automatic gap(output int c);
    logic [5:0] g;
    g = o_gain;
    for (c = 1; c < 3000; c++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_gain !== g) return;
    end
    n_errors++;
    complete_run();
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    for (int a = 1; a < 6; a++) look(8'(a), 6'h22);
    $display("test reset done");
    repeat (12) begin
      wr(8'h03, 8'(xs()));
      wr(8'h04, 8'(xs()) & 8'h7f);
      wr(8'h01, 8'(xs()));
      look(8'h03, clampg());
      look(8'h01, clampg());
    end
    $display("test random done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h04, 8'(k * 17) & 8'h7f);
      look(8'h04, clampg());
    end
    @(posedge i_sys_clk);
    #1 i_ce = 1'b0;
    wr(8'h03, 8'h00);
    i_ce = 1'b1;
    look(8'h03, clampg());
    wr(8'h01, 8'h30);
    wr(8'h04, 8'h8b);
    wr(8'h01, 8'h05);
    look(8'h01, 6'h2e);
    $display("test lockout done");
    wr(8'h03, 8'h02);
    i_over_threshold = 1'b1;
    gap(n);
    gap(n);
    check(32'(n), 32'h00000010);
    for (int i = 0; i < 60 && o_gain !== 6'h00; i++) gap(n);
    repeat (40) @(posedge i_sys_clk);
    look(8'h04, 6'h00);
    wr(8'h03, 8'h08);
    i_over_threshold = 1'b0;
    gap(n);
    gap(n);
    check(32'(n), 32'h00000010);
    for (int i = 0; i < 60 && o_gain !== 6'h2e; i++) gap(n);
    repeat (100) @(posedge i_sys_clk);
    look(8'h04, 6'h2e);
    $display("test stepping done");
    wr(8'h04, 8'h0b);
    wr(8'h01, 8'h10);
    look(8'h01, 6'h10);
    $display("test disable done");
    @(posedge i_sys_clk);
    #1 i_rst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    t_m = 8'h2b;
    m_m = 8'h4b;
    g_m = 8'h22;
    look(8'h01, 6'h22);
    look(8'h03, 6'h22);
    look(8'h04, 6'h22);
    $display("test reset again done");
    complete_run();
  end
endmodule
